// ---- logic/pio_pkg.sv ----
// constants and register map for the parallel i/o port bank
// Functional notes
// - port zero and port one each split into independent low and high bytes
// - port two has 16 lines, port three 15 without bit 14, four has 8
// - port five is 16 input-only lines; ports six to eight have 8 each
// - every pin level is latched once per state time, either direction
// - input pin: write updates latch only, read returns sampled pin
// - input pin: read-modify-write reads pin, stores result in latch
// - direction one enables driver; write lands in latch and on pin
// - output pin: reads and modify reads return the latch
// - ports 2,3,4,6,7,8 have per-pin open-drain select, drives low only
// - one threshold bit per byte; ports zero, one, two, three, five take two
// - direction and drive mode work whatever threshold is chosen
// - every line has one alternate function that software enables
// - alternate output reaches pin only when direction is output
// - some alternate outputs needed after reset set direction themselves
// - pin value is latch and alternate data, except pwm outputs
// - direction resets to input; alternate input reads the pin level
// - bus-type alternate functions switch direction by hardware
package pio_pkg;
  localparam int PIO_NBYTES = 14;
  localparam int PIO_NPINS = 112;
  // byte order: p0l p0h p1l p1h p2 p2 p3 p3 p4 p5 p5 p6 p7 p8
  localparam int PIO_P5_BYTE = 9;
  localparam int PIO_GAP_PIN = 62;
  localparam logic [13:0] PIO_OUT_BYTES = 14'h39ff;
  localparam logic [13:0] PIO_OD_BYTES = 14'h39f0;
  localparam logic [111:0] PIO_PIN_MASK =
    112'hffff_ffff_ffff_bfff_ffff_ffff_ffff;
  localparam logic [2:0] PIO_RGN_DATA = 3'h0;
  localparam logic [2:0] PIO_RGN_DIR = 3'h1;
  localparam logic [2:0] PIO_RGN_OD = 3'h2;
  localparam logic [2:0] PIO_RGN_THR = 3'h3;
  localparam logic [3:0] PIO_THR_LO_IDX = 4'h0;
  localparam logic [3:0] PIO_THR_HI_IDX = 4'h1;
  localparam logic [3:0] PIO_IDX_LIMIT = 4'he;
  localparam logic [7:0] PIO_LAT_RST = 8'h00;
  localparam logic [7:0] PIO_CTL_RST = 8'h00;
  localparam logic [13:0] PIO_THR_RST = 14'h0000;
  localparam int PIO_CLK_PERIOD_NS = 100;
  localparam int PIO_STATE_TIME_NS = 200;
  localparam int PIO_STATE_CLKS_I =
    (PIO_STATE_TIME_NS + PIO_CLK_PERIOD_NS - 1) / PIO_CLK_PERIOD_NS;
  localparam logic [3:0] PIO_STATE_LAST = 4'(PIO_STATE_CLKS_I - 1);
  typedef enum logic [1:0] {
    PIO_MODE_LATCH = 2'h0,
    PIO_MODE_ALT = 2'h1,
    PIO_MODE_HW = 2'h3
  } pio_mode_t;
endpackage

// ---- logic/pio_byte.sv ----
// one byte of port pins: latches, direction, drive and input sampling
`timescale 1ns/10ps
`default_nettype none
module pio_byte
  import pio_pkg::*;
#(
  parameter logic HAS_OUT = 1'b1,
  parameter logic HAS_OD = 1'b1,
  parameter logic [7:0] BIT_MASK = 8'hff,
  parameter logic [7:0] AUTO_MASK = 8'h00
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sample,
  input wire logic i_wr_lat,
  input wire logic i_wr_dir,
  input wire logic i_wr_od,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_pin,
  input wire logic [7:0] i_alt_oen,
  input wire logic [7:0] i_alt_out,
  input wire logic [7:0] i_alt_pwm,
  input wire logic [7:0] i_hw_den,
  input wire logic [7:0] i_hw_dir,
  output logic [7:0] o_rd,
  output logic [7:0] o_dir,
  output logic [7:0] o_od,
  output logic [7:0] o_alt_in,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe
);
  logic [7:0] lat_reg, dir_reg, od_reg;
  logic [7:0] sync1_reg, sync2_reg, in_reg;
  logic [7:0] out_reg, oe_reg;
  wire [7:0] dir_cap = HAS_OUT ? BIT_MASK : 8'h00;
  wire [7:0] od_cap = HAS_OD ? BIT_MASK : 8'h00;
  wire [7:0] auto_dir = AUTO_MASK & i_alt_oen;
  wire [7:0] sw_dir = dir_reg | auto_dir;
  wire [7:0] dir_eff = ((i_hw_den & i_hw_dir) | (~i_hw_den & sw_dir))
    & dir_cap;
  wire [7:0] alt_plain = i_alt_oen & ~i_alt_pwm & i_alt_out & lat_reg;
  wire [7:0] alt_pwm = i_alt_oen & i_alt_pwm & i_alt_out;
  wire [7:0] val = alt_plain | alt_pwm | (~i_alt_oen & lat_reg);
  wire [7:0] oe_next = dir_eff & (~od_reg | ~val);
  wire [7:0] out_next = val & ~od_reg;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lat_reg <= PIO_LAT_RST;
    end else if (i_wr_lat) begin
      lat_reg <= i_wdata & BIT_MASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      dir_reg <= PIO_CTL_RST;
      od_reg <= PIO_CTL_RST;
    end else begin
      if (i_wr_dir) begin
        dir_reg <= i_wdata & dir_cap;
      end
      if (i_wr_od) begin
        od_reg <= i_wdata & od_cap;
      end
    end
  end

  // data path only: left without reset so it settles from the pins
  always_ff @(posedge i_mclk) begin
    sync1_reg <= i_pin;
    sync2_reg <= sync1_reg;
  end

  // input latch cleared so alternate inputs never show unknowns
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      in_reg <= PIO_LAT_RST;
    end else if (i_sample) begin
      in_reg <= sync2_reg & BIT_MASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      out_reg <= 8'h00;
      oe_reg <= 8'h00;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign o_rd = (dir_reg & lat_reg) | (~dir_reg & in_reg);
  assign o_dir = dir_reg;
  assign o_od = od_reg;
  assign o_alt_in = in_reg;
  assign o_pin_out = out_reg;
  assign o_pin_oe = oe_reg;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_od_low_only: assert property (
    (o_pin_out & $past(od_reg)) == 8'h00)
    else $error("open drain pin driven high");
  a_alt_and_latch: assert property (
    ($past(i_alt_oen & ~i_alt_pwm & ~lat_reg) & o_pin_out) == 8'h00)
    else $error("alternate output not gated by latch");
  a_alt_needs_dir: assert property (
    ($past(~dir_reg & ~i_hw_den & ~auto_dir) & o_pin_oe) == 8'h00)
    else $error("pin driven while direction is input");
  a_sample_path: assert property (
    i_sample |=> o_alt_in == ($past(i_pin, 3) & BIT_MASK))
    else $error("input latch missed the pin level");
endmodule
`default_nettype wire

// ---- logic/pio_bank.sv ----
// parallel i/o port bank: register port, state-time divider, byte slices
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pio_bank
  import pio_pkg::*;
#(
  parameter logic [111:0] AUTO_DIR_MASK = 112'h0000
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [111:0] i_pin,
  input wire logic [111:0] i_alt_oen,
  input wire logic [111:0] i_alt_out,
  input wire logic [111:0] i_alt_pwm,
  input wire logic [111:0] i_hw_den,
  input wire logic [111:0] i_hw_dir,
  output logic [7:0] o_rdata,
  output logic [111:0] o_pin_out,
  output logic [111:0] o_pin_oe,
  output logic [111:0] o_alt_in,
  output logic [13:0] o_thr_cmos
);
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic state_en_reg;
  logic state_en_next;
  logic [13:0] thr_reg;
  logic [13:0] thr_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] rd_b [16];
  logic [7:0] dir_b [16];
  logic [7:0] od_b [16];

  // register decode
  wire [2:0] rgn = i_addr[6:4];
  wire [3:0] idx = i_addr[3:0];
  wire idx_ok = idx < PIO_IDX_LIMIT;
  wire sel_data = (rgn == PIO_RGN_DATA) && idx_ok;
  wire sel_dir = (rgn == PIO_RGN_DIR) && idx_ok;
  wire sel_od = (rgn == PIO_RGN_OD) && idx_ok;
  wire sel_thr_lo = (rgn == PIO_RGN_THR) && (idx == PIO_THR_LO_IDX);
  wire sel_thr_hi = (rgn == PIO_RGN_THR) && (idx == PIO_THR_HI_IDX);
  wire wr_thr_lo = i_wr && sel_thr_lo;
  wire wr_thr_hi = i_wr && sel_thr_hi;

  // state-time enable; one pulse every state time
  wire div_wrap = div_reg == PIO_STATE_LAST;
  assign div_next = div_wrap ? 4'h0 : div_reg + 4'h1;
  assign state_en_next = div_wrap;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      div_reg <= 4'h0;
      state_en_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      state_en_reg <= state_en_next;
    end
  end

  // one selection bit per byte; the pad cells use it, logic ignores it
  assign thr_next = {
    wr_thr_hi ? i_wdata[5:0] : thr_reg[13:8],
    wr_thr_lo ? i_wdata : thr_reg[7:0]
  };

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      thr_reg <= PIO_THR_RST;
    end else begin
      thr_reg <= thr_next;
    end
  end

  genvar b;
  generate
    for (b = 0; b < 16; b = b + 1) begin : g_byte
      if (b < PIO_NBYTES) begin : g_live
        wire hit = idx == 4'(b);
        pio_byte #(
          .HAS_OUT(PIO_OUT_BYTES[b]),
          .HAS_OD(PIO_OD_BYTES[b]),
          .BIT_MASK(PIO_PIN_MASK[b*8 +: 8]),
          .AUTO_MASK(AUTO_DIR_MASK[b*8 +: 8])
        ) u_byte (
          .i_mclk(i_mclk),
          .i_rst(i_rst),
          .i_sample(state_en_reg),
          .i_wr_lat(i_wr && sel_data && hit),
          .i_wr_dir(i_wr && sel_dir && hit),
          .i_wr_od(i_wr && sel_od && hit),
          .i_wdata(i_wdata),
          .i_pin(i_pin[b*8 +: 8]),
          .i_alt_oen(i_alt_oen[b*8 +: 8]),
          .i_alt_out(i_alt_out[b*8 +: 8]),
          .i_alt_pwm(i_alt_pwm[b*8 +: 8]),
          .i_hw_den(i_hw_den[b*8 +: 8]),
          .i_hw_dir(i_hw_dir[b*8 +: 8]),
          .o_rd(rd_b[b]),
          .o_dir(dir_b[b]),
          .o_od(od_b[b]),
          .o_alt_in(o_alt_in[b*8 +: 8]),
          .o_pin_out(o_pin_out[b*8 +: 8]),
          .o_pin_oe(o_pin_oe[b*8 +: 8])
        );
      end else begin : g_pad
        assign rd_b[b] = 8'h00;
        assign dir_b[b] = 8'h00;
        assign od_b[b] = 8'h00;
      end
    end
  endgenerate

  // read mux; a modify cycle is a read here followed by a write
  wire [7:0] rd_data = sel_data ? rd_b[idx] : 8'h00;
  wire [7:0] rd_dir = sel_dir ? dir_b[idx] : 8'h00;
  wire [7:0] rd_od = sel_od ? od_b[idx] : 8'h00;
  wire [7:0] rd_thr = sel_thr_lo ? thr_reg[7:0]
    : sel_thr_hi ? {2'h0, thr_reg[13:8]} : 8'h00;
  wire [7:0] rd_any = rd_data | rd_dir | rd_od | rd_thr;
  // data only in the cycle after the strobe, zero otherwise
  assign rdata_next = i_rd ? rd_any : 8'h00;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_thr_cmos = thr_reg;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_state_pulse: assert property (
    state_en_reg |=> !state_en_reg ##1 state_en_reg)
    else $error("state time pulse spacing wrong");
  a_input_only: assert property (
    o_pin_oe[PIO_P5_BYTE*8 +: 16] == 16'h0000)
    else $error("input-only port drives a pin");
  a_gap_pin: assert property (
    !o_pin_oe[PIO_GAP_PIN] && !o_alt_in[PIO_GAP_PIN])
    else $error("missing port three line is active");
  a_dir_reset: assert property (
    $past(i_rst) |-> (o_pin_oe == 112'h0000))
    else $error("pin driven right after reset");
  a_read_timing: assert property (
    i_rd && sel_data && (idx == 4'h0)
      |=> o_rdata == $past(rd_b[0]))
    else $error("read data not returned one cycle later");
  a_read_idle: assert property (
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside the answer cycle");
  a_write_drives: assert property (
    i_wr && sel_data && (idx == 4'h4) && !i_rd
      ##1 (dir_b[4] == 8'hff) && (od_b[4] == 8'h00)
      && (i_alt_oen[39:32] == 8'h00) && (i_hw_den[39:32] == 8'h00)
      |=> o_pin_out[39:32] == $past(i_wdata, 2))
    else $error("written value not driven on output pins");
  a_od_cap: assert property (
    (od_b[0] | od_b[1] | od_b[2] | od_b[3] | od_b[9] | od_b[10]) == 8'h00)
    else $error("open drain set on a port without it");
  a_thr_indep: assert property (
    wr_thr_lo |=> (dir_b[0] == $past(dir_b[0])))
    else $error("threshold write disturbed direction");

  c_sample: cover property (state_en_reg && (o_alt_in != 112'h0000));
  c_out_write: cover property (
    i_wr && sel_dir ##1 i_wr && sel_data);
  c_od_low: cover property ((o_pin_oe & ~o_pin_out) != 112'h0000);
  c_read_back: cover property (i_rd && sel_data ##1 o_rdata != 8'h00);
endmodule
`default_nettype wire

// ---- testbench/pio_pins_model.sv ----
// far-side pin model: device drive, external source, board pull-ups
`timescale 1ns/10ps
`default_nettype none
module pio_pins_model (
  input wire logic [111:0] i_out,
  input wire logic [111:0] i_oe,
  input wire logic [111:0] i_ext_val,
  input wire logic [111:0] i_ext_en,
  output logic [111:0] o_pin
);
  // undriven lines float up through the pull-ups, so open drain wire-ands
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val) |
    (~i_oe & ~i_ext_en);
endmodule
`default_nettype wire

// ---- testbench/parallel_io_port_bank_bench.sv ----
// self-checking bench for the parallel i/o port bank
`timescale 1ns/10ps
`default_nettype none
module parallel_io_port_bank_bench;
  import pio_pkg::*;
  localparam logic [111:0] AUTO = 112'h0001_0000_0000_0000;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [6:0] i_addr = '0;
  logic [7:0] i_wdata = '0;
  logic [7:0] o_rdata;
  logic [111:0] i_pin, o_pin_out, o_pin_oe, o_alt_in;
  logic [111:0] ext_val = '0, ext_en = '0, i_hw_den = '0, i_hw_dir = '0;
  logic [111:0] i_alt_oen = '0, i_alt_out = '0, i_alt_pwm = '0;
  logic [13:0] o_thr_cmos;
  int failures = 0;
  int n_compared = 0;

  pio_bank #(.AUTO_DIR_MASK(AUTO)) pio_bank_inst (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_pin(i_pin), .i_alt_oen(i_alt_oen),
    .i_alt_out(i_alt_out), .i_alt_pwm(i_alt_pwm), .i_hw_den(i_hw_den),
    .i_hw_dir(i_hw_dir), .o_rdata(o_rdata), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_alt_in(o_alt_in), .o_thr_cmos(o_thr_cmos));
  pio_pins_model pio_pins_model_inst (.i_out(o_pin_out), .i_oe(o_pin_oe),
    .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pin(i_pin));

  initial begin
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk14(input logic [13:0] got, input logic [13:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: thr %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk8(o_rdata, exp);
  endtask

  // covers the two-flop sync plus one state pulse
  task automatic settle();
    repeat (6) @(posedge i_mclk);
    #1;
  endtask

  task automatic t_input();
    settle();
    rd(7'h14, 8'h00);
    rd(7'h04, 8'hff);
    @(posedge i_mclk);
    ext_en[39:32] <= 8'hff;
    ext_val[39:32] <= 8'h3c;
    wr(7'h04, 8'ha5);
    settle();
    rd(7'h04, 8'h3c);
    chk8(o_pin_oe[39:32], 8'h00);
    chk8(o_alt_in[39:32], 8'h3c);
  endtask

  task automatic t_output();
    wr(7'h14, 8'h0f);
    rd(7'h04, 8'h35);
    wr(7'h04, 8'hca);
    wr(7'h14, 8'hff);
    settle();
    chk8(o_pin_out[39:32], 8'hca);
    chk8(o_pin_oe[39:32], 8'hff);
    rd(7'h04, 8'hca);
    chk8(o_alt_in[39:32], 8'hca);
  endtask

  task automatic t_drain();
    @(posedge i_mclk);
    ext_en[39:32] <= 8'h00;
    wr(7'h24, 8'hff);
    settle();
    chk8(o_pin_out[39:32], 8'h00);
    chk8(o_pin_oe[39:32], 8'h35);
    chk8(o_alt_in[39:32], 8'hca);
    wr(7'h20, 8'hff);
    rd(7'h20, 8'h00);
    rd(7'h24, 8'hff);
    wr(7'h24, 8'h00);
    wr(7'h30, 8'ha5);
    wr(7'h31, 8'h3f);
    settle();
    chk14(o_thr_cmos, 14'h3fa5);
    chk8(o_pin_oe[39:32], 8'hff);
    rd(7'h30, 8'ha5);
  endtask

  task automatic t_alt();
    @(posedge i_mclk);
    i_alt_oen[39:32] <= 8'hff;
    i_alt_out[39:32] <= 8'hf0;
    settle();
    chk8(o_pin_out[39:32], 8'hc0);
    @(posedge i_mclk);
    i_alt_pwm[39:32] <= 8'hff;
    settle();
    chk8(o_pin_out[39:32], 8'hf0);
    wr(7'h14, 8'h00);
    settle();
    chk8(o_pin_oe[39:32], 8'h00);
    @(posedge i_mclk);
    i_hw_den[39:32] <= 8'hff;
    i_hw_dir[39:32] <= 8'h0f;
    settle();
    chk8(o_pin_oe[39:32], 8'h0f);
    @(posedge i_mclk);
    i_alt_oen <= AUTO;
    i_alt_out <= AUTO;
    i_alt_pwm <= '0;
    i_hw_den <= '0;
    wr(7'h06, 8'h01);
    settle();
    chk8(o_pin_oe[55:48], 8'h01);
    chk8(o_pin_oe[39:32], 8'h00);
  endtask

  task automatic t_map();
    wr(7'h19, 8'hff);
    rd(7'h19, 8'h00);
    wr(7'h17, 8'hff);
    rd(7'h17, 8'hbf);
    rd(7'h40, 8'h00);
    wr(7'h12, 8'hff);
    wr(7'h13, 8'hff);
    wr(7'h02, 8'h11);
    wr(7'h03, 8'h22);
    rd(7'h02, 8'h11);
    rd(7'h03, 8'h22);
  endtask

  task automatic print_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_input();
    t_output();
    t_drain();
    t_alt();
    t_map();
    print_verdict();
  end

  initial begin
    #100000;
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
